// ---- shared/mcrio_pkg.sv ----
// Behaviour
// - Cell output is registered sum-of-products or the combinational sum directly.
// - Cell clock is global, global with enable, or a product-term clock.
// - Gated global mode loads only while the enable is high, else holds.
// - Product-term clock comes from dedicated inputs, buried cells or I/O pins.
// - Small variant: one global clock; extended: two, true or inverted pin.
// - Product-term preset and clear are asynchronous and active high; the cell samples them on CORE_CLK.
// - Clear may be driven per register by the active-low global clear pin.
// - Every cell flip-flop starts low at power-up.
// - Extended variant: pin feeds the flip-flop D input directly.
// - Each cell has five own product terms plus cluster expander terms.
// - Each cluster takes 36 general inputs from the routing array.
// - Routing array carries all sources; config bit ANDs each into cluster.
// - Each pin is input, output or both; its enable is chosen or tied.
// - Small variant: two output enables from two active-low enable pins.
// - Extended variant: six output enables from pins, cells or enable pins.
package mcrio_pkg;
  localparam int NUM_CELLS    = 16;
  localparam int NUM_PINS     = 16;
  localparam int NUM_DED      = 4;
  localparam int ARRAY_W      = NUM_DED + NUM_PINS + NUM_CELLS;
  localparam int CLUSTER_IN   = 36;
  localparam int NUM_PTERMS   = 5;
  localparam int NUM_EXP      = 4;
  localparam int NUM_OE       = 6;
  localparam int NUM_OE_SMALL = 2;
  localparam int SEL_W        = 6;
  localparam int OE_SEL_W     = 3;
  localparam logic RESET_STATE = 1'b0;

  typedef enum logic [1:0] {
    MCRIO_CLK_GLOBAL, MCRIO_CLK_GATED, MCRIO_CLK_PTERM
  } mcrio_clk_e;

  // Codes 0..5 pick a global enable; 6 ties off, 7 ties on.
  localparam logic [OE_SEL_W-1:0] OE_TIE_OFF = 3'h6;
  localparam logic [OE_SEL_W-1:0] OE_TIE_ON  = 3'h7;

  typedef enum logic [2:0] {
    MCRIO_OES_PIN1, MCRIO_OES_PIN1_N, MCRIO_OES_PIN2, MCRIO_OES_PIN2_N,
    MCRIO_OES_IOPIN, MCRIO_OES_CELL
  } mcrio_oesrc_e;
endpackage

// ---- design/mcrio_cell.sv ----
`timescale 1ns/1ps
`default_nettype none
// One cell: product terms, sum, and an emulated flip-flop on CORE_CLK.
// Asynchronous preset and clear are sampled synchronously here because the
// block runs on one clock; the set/clear then acts on the same edge.
module mcrio_cell
  import mcrio_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [CLUSTER_IN-1:0]     cluster_in,
  input  wire logic [NUM_PTERMS*CLUSTER_IN-1:0] and_mask,
  input  wire logic [NUM_PTERMS*CLUSTER_IN-1:0] inv_mask,
  input  wire logic [NUM_EXP-1:0]        expander,
  input  wire logic                      comb_mode,
  input  wire logic [1:0]                clk_mode,
  input  wire logic                      g_tick,
  input  wire logic                      clk_en,
  input  wire logic                      pterm_tick,
  input  wire logic                      preset,
  input  wire logic                      clear,
  input  wire logic                      use_gclr,
  input  wire logic                      gclr_n,
  input  wire logic                      fast_sel,
  input  wire logic                      fast_d,
  output logic                           q_out,
  output logic                           cell_out
);
  logic [NUM_PTERMS-1:0] pterm;
  logic                  sop;
  logic                  d_in;
  logic                  load;
  logic                  clr_all;
  logic                  q;

  genvar g;
  generate
    for (g = 0; g < NUM_PTERMS; g++) begin : g_pt
      assign pterm[g] = &((cluster_in ^ inv_mask[g*CLUSTER_IN +: CLUSTER_IN])
                          | ~and_mask[g*CLUSTER_IN +: CLUSTER_IN]);
    end
  endgenerate
  assign sop  = (|pterm) | (|expander);
  assign d_in = fast_sel ? fast_d : sop;
  assign load = (clk_mode == MCRIO_CLK_GLOBAL) ? g_tick :
                (clk_mode == MCRIO_CLK_GATED)  ? (g_tick & clk_en) :
                (clk_mode == MCRIO_CLK_PTERM)  ? pterm_tick : 1'b0;
  assign clr_all = clear | (use_gclr & ~gclr_n);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= RESET_STATE;
    end else if (clr_all) begin
      q <= 1'b0;
    end else if (preset) begin
      q <= 1'b1;
    end else if (load) begin
      q <= d_in;
    end
  end
  assign q_out = q;
  assign cell_out = comb_mode ? sop : q;

  a_clear_wins: assert property (@(posedge clk) disable iff (!rst_n)
    clr_all |=> !q) else $error("clear did not force low");
  a_gated_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_mode == MCRIO_CLK_GATED && !clk_en && !clr_all && !preset)
    |=> $stable(q)) else $error("gated cell changed");
  a_preset_high: assert property (@(posedge clk) disable iff (!rst_n)
    (preset && !clr_all) |=> q) else $error("preset failed");
  a_global_load: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_mode == MCRIO_CLK_GLOBAL && g_tick && !clr_all && !preset)
    |=> q == $past(d_in)) else $error("global load failed");
  a_pterm_load: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_mode == MCRIO_CLK_PTERM && pterm_tick && !clr_all && !preset)
    |=> q == $past(d_in)) else $error("pterm load failed");
  a_comb_out: assert property (@(posedge clk) disable iff (!rst_n)
    comb_mode |-> cell_out == sop) else $error("comb path wrong");
  a_gclr_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (use_gclr && !gclr_n) |=> !q) else $error("global clear failed");
endmodule
`default_nettype wire

// ---- design/mcrio_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// A cluster of cells fed from the routing array, with pin output enables.
// Clock pins are sampled levels; a rising edge of the chosen clock becomes a
// one-cycle load tick on CORE_CLK.
module mcrio_top
  import mcrio_pkg::*;
(
  input  wire logic                                 CORE_CLK,
  input  wire logic                                 RESET_N,
  input  wire logic                                 EXTENDED,
  input  wire logic [NUM_DED-1:0]                   DED_IN,
  input  wire logic                                 GLOBAL_CLOCK_PIN_FIRST,
  input  wire logic                                 GLOBAL_CLOCK_PIN_SECOND,
  input  wire logic                                 GLOBAL_CLEAR_PIN_N,
  input  wire logic                                 OUTPUT_ENABLE_PIN_FIRST_N,
  input  wire logic                                 OUTPUT_ENABLE_PIN_SECOND_N,
  input  wire logic [NUM_PINS-1:0]                  PIN_IN,
  output logic      [NUM_PINS-1:0]                  PIN_OUT,
  output logic      [NUM_PINS-1:0]                  PIN_OE,
  input  wire logic [ARRAY_W-1:0]                   ROUTE_EN [CLUSTER_IN],
  input  wire logic [SEL_W-1:0]                     ROUTE_SEL [CLUSTER_IN],
  input  wire logic [NUM_PTERMS*CLUSTER_IN-1:0]     AND_MASK [NUM_CELLS],
  input  wire logic [NUM_PTERMS*CLUSTER_IN-1:0]     INV_MASK [NUM_CELLS],
  input  wire logic [NUM_CELLS-1:0]                 EXP_SHARE [NUM_CELLS],
  input  wire logic [NUM_CELLS-1:0]                 COMB_MODE,
  input  wire logic [1:0]                           CLK_MODE [NUM_CELLS],
  input  wire logic [NUM_CELLS-1:0]                 GCLK_SEL,
  input  wire logic [1:0]                           GCLK_SRC [2],
  input  wire logic [NUM_CELLS-1:0]                 CLK_EN_SRC,
  input  wire logic [SEL_W-1:0]                     PTCLK_SEL [NUM_CELLS],
  input  wire logic [SEL_W-1:0]                     PRESET_SEL [NUM_CELLS],
  input  wire logic [SEL_W-1:0]                     CLEAR_SEL [NUM_CELLS],
  input  wire logic [NUM_CELLS-1:0]                 PRESET_ON,
  input  wire logic [NUM_CELLS-1:0]                 CLEAR_ON,
  input  wire logic [NUM_CELLS-1:0]                 USE_GCLR,
  input  wire logic [NUM_CELLS-1:0]                 FAST_SEL,
  input  wire logic [2:0]                           OE_SRC [NUM_OE],
  input  wire logic [SEL_W-1:0]                     OE_NODE [NUM_OE],
  input  wire logic [OE_SEL_W-1:0]                  PIN_OE_SEL [NUM_PINS],
  output logic      [NUM_CELLS-1:0]                 CELL_Q
);
  import mcrio_pkg::*;

  logic [ARRAY_W-1:0]    route_array;
  logic [CLUSTER_IN-1:0] cluster_in;
  logic [NUM_CELLS-1:0]  cell_out;
  logic [NUM_CELLS-1:0]  cell_q;
  logic [1:0]            gclk_lvl;
  logic [1:0]            gclk_prev;
  logic [1:0]            gclk_tick;
  logic [NUM_CELLS-1:0]  pt_prev;
  logic [NUM_CELLS-1:0]  pt_lvl;
  logic [NUM_OE-1:0]     goe;
  logic [NUM_PINS-1:0]   next_oe;

  assign route_array = {cell_out, PIN_IN, DED_IN};

  genvar i;
  generate
    for (i = 0; i < CLUSTER_IN; i++) begin : g_route
      assign cluster_in[i] = ROUTE_EN[i][ROUTE_SEL[i]]
                             & route_array[ROUTE_SEL[i]];
    end
  endgenerate

  generate
    for (i = 0; i < 2; i++) begin : g_gclk
      assign gclk_lvl[i] =
        (i == 1 && !EXTENDED) ? 1'b0 :
        (GCLK_SRC[i][0] ? GLOBAL_CLOCK_PIN_SECOND : GLOBAL_CLOCK_PIN_FIRST)
        ^ (EXTENDED & GCLK_SRC[i][1]);
    end
  endgenerate
  assign gclk_tick = gclk_lvl & ~gclk_prev;

  generate
    for (i = 0; i < NUM_OE; i++) begin : g_oe
      logic src;
      assign src =
        (OE_SRC[i] == MCRIO_OES_PIN1)   ? ~OUTPUT_ENABLE_PIN_FIRST_N :
        (OE_SRC[i] == MCRIO_OES_PIN1_N) ?  OUTPUT_ENABLE_PIN_FIRST_N :
        (OE_SRC[i] == MCRIO_OES_PIN2)   ? ~OUTPUT_ENABLE_PIN_SECOND_N :
        (OE_SRC[i] == MCRIO_OES_PIN2_N) ?  OUTPUT_ENABLE_PIN_SECOND_N :
        (OE_SRC[i] == MCRIO_OES_IOPIN)  ? PIN_IN[OE_NODE[i][3:0]] :
        (OE_SRC[i] == MCRIO_OES_CELL)   ? cell_out[OE_NODE[i][3:0]] : 1'b0;
      assign goe[i] = EXTENDED ? src :
                      (i == 0) ? ~OUTPUT_ENABLE_PIN_FIRST_N :
                      (i == 1) ? ~OUTPUT_ENABLE_PIN_SECOND_N : 1'b0;
    end
  endgenerate

  generate
    for (i = 0; i < NUM_PINS; i++) begin : g_pin
      assign next_oe[i] = (PIN_OE_SEL[i] == OE_TIE_ON)  ? 1'b1 :
                          (PIN_OE_SEL[i] == OE_TIE_OFF) ? 1'b0 :
                          goe[PIN_OE_SEL[i]];
    end
  endgenerate

  generate
    for (i = 0; i < NUM_CELLS; i++) begin : g_cell
      logic [NUM_EXP-1:0] exp_in;
      logic               ptick;
      // Expanders: four ORs, each over up to four shared neighbour outputs.
      assign exp_in = {NUM_EXP{1'b0}} |
        {|(EXP_SHARE[i][3:0]  & cell_out[3:0]),
         |(EXP_SHARE[i][7:4]  & cell_out[7:4]),
         |(EXP_SHARE[i][11:8] & cell_out[11:8]),
         |(EXP_SHARE[i][15:12] & cell_out[15:12])};
      assign pt_lvl[i] = route_array[PTCLK_SEL[i]];
      assign ptick = pt_lvl[i] & ~pt_prev[i];
      mcrio_cell u_cell (
        .clk        (CORE_CLK),
        .rst_n      (RESET_N),
        .cluster_in (cluster_in),
        .and_mask   (AND_MASK[i]),
        .inv_mask   (INV_MASK[i]),
        .expander   (exp_in),
        .comb_mode  (COMB_MODE[i]),
        .clk_mode   (CLK_MODE[i]),
        .g_tick     (gclk_tick[GCLK_SEL[i] & EXTENDED]),
        .clk_en     (CLK_EN_SRC[i] ? cluster_in[i] : 1'b1),
        .pterm_tick (ptick),
        .preset     (PRESET_ON[i] & cluster_in[PRESET_SEL[i]]),
        .clear      (CLEAR_ON[i] & cluster_in[CLEAR_SEL[i]]),
        .use_gclr   (USE_GCLR[i]),
        .gclr_n     (GLOBAL_CLEAR_PIN_N),
        .fast_sel   (FAST_SEL[i] & EXTENDED),
        .fast_d     (PIN_IN[i]),
        .q_out      (cell_q[i]),
        .cell_out   (cell_out[i])
      );
    end
  endgenerate

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      gclk_prev <= 2'h0;
      pt_prev   <= '0;
      PIN_OUT   <= '0;
      PIN_OE    <= '0;
      CELL_Q    <= '0;
    end else begin
      gclk_prev <= gclk_lvl;
      pt_prev   <= pt_lvl;
      PIN_OUT   <= cell_out;
      PIN_OE    <= next_oe;
      CELL_Q    <= cell_q;
    end
  end

  a_oe_tied: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    PIN_OE_SEL[0] == OE_TIE_ON |=> PIN_OE[0]) else $error("tie on");
  a_small_oe: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (!EXTENDED && !OUTPUT_ENABLE_PIN_FIRST_N) |-> goe[0])
    else $error("small oe polarity");
endmodule
`default_nettype wire

// ---- test/mcrio_board.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcrio_board
  import mcrio_pkg::*;
(
  input  wire logic                clk,
  input  wire logic [NUM_PINS-1:0] dev_out,
  input  wire logic [NUM_PINS-1:0] dev_oe,
  input  wire logic [NUM_PINS-1:0] drv_en,
  input  wire logic [NUM_PINS-1:0] drv_val,
  output logic      [NUM_PINS-1:0] lvl
);
  logic [NUM_PINS-1:0] stale;
  // A pin nobody drives shows the inverse of its last level.
  always_ff @(posedge clk) begin
    stale <= ~lvl;
  end
  assign lvl = (dev_oe & dev_out) | (~dev_oe & drv_en & drv_val)
             | (~dev_oe & ~drv_en & stale);
endmodule
`default_nettype wire

// ---- test/mcrio_top_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcrio_top_tb_top;
  import mcrio_pkg::*;
  logic                             clk, rst_n, ext, gck1, gck2;
  logic                             gclr_n, oe1_n, oe2_n;
  logic [NUM_DED-1:0]               ded;
  logic [NUM_PINS-1:0]              pin_in, pin_out, pin_oe, drv_en, drv_val;
  logic [ARRAY_W-1:0]               route_en [CLUSTER_IN];
  logic [SEL_W-1:0]                 route_sel [CLUSTER_IN];
  logic [SEL_W-1:0]                 ptclk_sel [NUM_CELLS];
  logic [SEL_W-1:0]                 pre_sel [NUM_CELLS];
  logic [SEL_W-1:0]                 clr_sel [NUM_CELLS];
  logic [SEL_W-1:0]                 oe_node [NUM_OE];
  logic [NUM_PTERMS*CLUSTER_IN-1:0] and_mask [NUM_CELLS];
  logic [NUM_PTERMS*CLUSTER_IN-1:0] inv_mask [NUM_CELLS];
  logic [NUM_CELLS-1:0]             exp_share [NUM_CELLS];
  logic [NUM_CELLS-1:0]             comb, gclk_sel, en_src, pre_on, clr_on;
  logic [NUM_CELLS-1:0]             use_gclr, fast_sel, cell_q;
  logic [1:0]                       clk_mode [NUM_CELLS];
  logic [1:0]                       gclk_src [2];
  logic [2:0]                       oe_src [NUM_OE];
  logic [OE_SEL_W-1:0]              oe_sel [NUM_PINS];
  int                               fails, num_checks;

  mcrio_top uut (
    .CORE_CLK(clk), .RESET_N(rst_n), .EXTENDED(ext), .DED_IN(ded),
    .GLOBAL_CLOCK_PIN_FIRST(gck1), .GLOBAL_CLOCK_PIN_SECOND(gck2),
    .GLOBAL_CLEAR_PIN_N(gclr_n), .OUTPUT_ENABLE_PIN_FIRST_N(oe1_n),
    .OUTPUT_ENABLE_PIN_SECOND_N(oe2_n), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .ROUTE_EN(route_en),
    .ROUTE_SEL(route_sel), .AND_MASK(and_mask), .INV_MASK(inv_mask),
    .EXP_SHARE(exp_share), .COMB_MODE(comb), .CLK_MODE(clk_mode),
    .GCLK_SEL(gclk_sel), .GCLK_SRC(gclk_src), .CLK_EN_SRC(en_src),
    .PTCLK_SEL(ptclk_sel), .PRESET_SEL(pre_sel), .CLEAR_SEL(clr_sel),
    .PRESET_ON(pre_on), .CLEAR_ON(clr_on), .USE_GCLR(use_gclr),
    .FAST_SEL(fast_sel), .OE_SRC(oe_src), .OE_NODE(oe_node),
    .PIN_OE_SEL(oe_sel), .CELL_Q(cell_q));
  mcrio_board board (.clk(clk), .dev_out(pin_out), .dev_oe(pin_oe),
    .drv_en(drv_en), .drv_val(drv_val), .lvl(pin_in));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Waits a bounded time for a cell pair to reach a value.
  task automatic wait_q(input logic [1:0] v);
    for (int n = 0; n < 10 && cell_q[1:0] !== v; n++) settle(1);
    chk(16'(cell_q[1:0]), 16'(v));
    if (cell_q[1:0] !== v) wrap_up();
  endtask

  task automatic tick(input logic second);
    @(posedge clk);
    if (second) gck2 <= 1'b1;
    else gck1 <= 1'b1;
    repeat (2) @(posedge clk);
    gck1 <= 1'b0;
    gck2 <= 1'b0;
  endtask

  task automatic t_clocks;
    @(posedge clk);
    fast_sel <= 16'h0003;
    drv_val <= 16'h0003;
    tick(1'b0);
    wait_q(2'h3);
    chk(16'(pin_out[1:0]), 16'h0003);
    gclk_src[0] <= 2'h1;
    drv_val <= 16'h0000;
    tick(1'b0);
    settle(6);
    chk(16'(cell_q[1:0]), 16'h0003);
    tick(1'b1);
    wait_q(2'h0);
    gclk_src[0] <= 2'h2;
    drv_val <= 16'h0003;
    wait_q(2'h3);
    drv_val <= 16'h0000;
    gck1 <= 1'b1;
    settle(6);
    chk(16'(cell_q[1:0]), 16'h0003);
    gck1 <= 1'b0;
    wait_q(2'h0);
    gclk_src[0] <= 2'h0;
    $display("test clocks done");
  endtask

  task automatic t_gated_clear;
    @(posedge clk);
    clk_mode[0] <= 2'h1;
    drv_val <= 16'h0003;
    tick(1'b0);
    wait_q(2'h2);
    ded[0] <= 1'b1;
    tick(1'b0);
    wait_q(2'h3);
    clk_mode[0] <= 2'h0;
    use_gclr[0] <= 1'b1;
    gclr_n <= 1'b0;
    wait_q(2'h2);
    gclr_n <= 1'b1;
    pre_on[0] <= 1'b1;
    pre_sel[0] <= 6'h01;
    ded[1] <= 1'b1;
    wait_q(2'h3);
    clr_on[0] <= 1'b1;
    clr_sel[0] <= 6'h02;
    ded[2] <= 1'b1;
    wait_q(2'h2);
    $display("test gated and clear done");
  endtask

  task automatic t_enables;
    @(posedge clk);
    ext <= 1'b0;
    oe_sel[0] <= OE_TIE_ON;
    settle(3);
    chk(16'(pin_oe[0]), 16'h0001);
    oe_sel[0] <= 3'h0;
    oe1_n <= 1'b0;
    settle(3);
    chk(16'(pin_oe[0]), 16'h0001);
    oe1_n <= 1'b1;
    settle(3);
    chk(16'(pin_oe[0]), 16'h0000);
    oe_sel[0] <= 3'h1;
    oe2_n <= 1'b0;
    settle(3);
    chk(16'(pin_oe[0]), 16'h0001);
    ext <= 1'b1;
    oe1_n <= 1'b0;
    oe_sel[0] <= 3'h0;
    settle(3);
    chk(16'(pin_oe[0]), 16'h0001);
    oe_sel[0] <= 3'h1;
    settle(3);
    chk(16'(pin_oe[0]), 16'h0000);
    oe_sel[0] <= 3'h4;
    oe_node[4] <= 6'h06;
    drv_val <= 16'h0044;
    settle(3);
    chk(16'(pin_oe[0]), 16'h0001);
    oe_sel[0] <= OE_TIE_OFF;
    settle(3);
    chk(16'(pin_oe[0]), 16'h0000);
    $display("test enables done");
  endtask

  // Comb output, expander, product-term clock and routing gate.
  task automatic t_logic;
    @(posedge clk);
    comb[2] <= 1'b1;
    comb[4] <= 1'b1;
    and_mask[2] <= {NUM_PTERMS{36'h0_0000_0008}};
    and_mask[3] <= {NUM_PTERMS{36'h0_0008_0000}};
    and_mask[4] <= {NUM_PTERMS{36'h0_0000_0004}};
    inv_mask[4] <= {NUM_PTERMS{36'h0_0000_0004}};
    exp_share[4] <= 16'h0004;
    clk_mode[3] <= 2'h2;
    ptclk_sel[3] <= 6'h03;
    settle(3);
    chk(16'(pin_out[4:2]), 16'h0002);
    chk(16'(cell_q[3:2]), 16'h0003);
    ded[3] <= 1'b1;
    settle(3);
    chk(16'(pin_out[4:2]), 16'h0005);
    chk(16'(cell_q[3:2]), 16'h0001);
    route_en[3] <= '0;
    settle(3);
    chk(16'(pin_out[4:2]), 16'h0000);
    $display("test logic done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    {rst_n, gck1, gck2, ded, comb, gclk_sel, pre_on, clr_on} = '0;
    {use_gclr, fast_sel, drv_val} = '0;
    {ext, gclr_n, oe1_n, oe2_n, en_src, drv_en} = '1;
    gclk_src[0] = 2'h0;
    gclk_src[1] = 2'h1;
    foreach (route_en[j]) route_en[j] = '1;
    foreach (route_sel[j]) route_sel[j] = SEL_W'(j);
    foreach (and_mask[i]) begin
      {and_mask[i], inv_mask[i], exp_share[i]} = '0;
      {ptclk_sel[i], pre_sel[i], clr_sel[i], clk_mode[i]} = '0;
    end
    foreach (oe_src[k]) {oe_src[k], oe_node[k]} = {3'(k), 6'h00};
    foreach (oe_sel[p]) oe_sel[p] = OE_TIE_OFF;
    settle(10);
    rst_n <= 1'b1;
    settle(2);
    chk(cell_q, 16'h0000);
    chk(pin_out, 16'h0000);
    t_clocks();
    t_gated_clear();
    t_enables();
    t_logic();
    wrap_up();
  end
endmodule
`default_nettype wire
